// file: pkg/ckt_pkg.sv
// Purpose: Constants shared by the clock timer block.
// Assumes: APB byte address is four times the register index.
// Notes: Register numbers below are word indices, not byte addresses.
package ckt_pkg;
    localparam logic [11:0] CKT_IDX_STAGE = 12'h02e0;
    localparam logic [11:0] CKT_IDX_MASK = 12'h02e8;
    localparam logic [11:0] CKT_IDX_CAUSE = 12'h02e9;
    localparam logic [11:0] CKT_IDX_CTRL = 12'h02ee;
    localparam int CKT_AW = 14;
    localparam int CKT_BIT_STROBE = 3;
    localparam int CKT_BIT_STOPWATCH_RUN_CONTROL = 2;
    localparam int CKT_BIT_PORT0 = 0;
    localparam int CKT_BIT_LCD = 3;
    localparam logic [3:0] CKT_STAGE_RST = 4'h0;
    localparam logic [2:0] CKT_MASK_RST = 3'h0;
    localparam logic [2:0] CKT_CAUSE_RST = 3'h0;
    // Chain input rate and clock rate; the tick is a parameter of the top.
    localparam int CKT_CLK_HZ = 125000000;
    localparam int CKT_BASE_HZ = 256;
    localparam int CKT_TICK_CYCLES = CKT_CLK_HZ / CKT_BASE_HZ;
    localparam int CKT_CHAIN_W = 7;
endpackage

// file: hdl/ckt_edge_flag.sv
// Purpose: One sticky cause flag set on a falling edge, cleared on read.
// Assumes: Stage input is a registered signal on pclk.
// Notes: A set in the clearing cycle wins.
`timescale 1ns/1ps
module ckt_edge_flag
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Event and clear
    input wire logic stage,
    input wire logic clear,
    // Flag
    output logic flag
);
    import ckt_pkg::*;
    logic prev_reg;
    logic prev_next;
    logic flag_reg;
    logic flag_next;
    logic fall;

    always_comb
    begin
        prev_next = stage;
        fall = prev_reg & ~stage;
        flag_next = flag_reg;
        if (clear)
        begin
            flag_next = 1'b0;
        end
        if (fall)
        begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_reg <= 1'b0;
            flag_reg <= 1'b0;
        end
        else
        begin
            prev_reg <= prev_next;
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;

    a_set_wins_clear: assert property (@(posedge pclk)
        disable iff (!presetn)
        fall |=> flag_reg)
        else $error("cause flag missed a falling edge");
endmodule

// file: hdl/ckt_clock_timer.sv
// Purpose: Clock timer with divider chain, masks and cause flags on APB.
// Assumes: APB master per protocol; zero wait states.
// Notes: Chain stages toggle at 256 Hz base tick divided by two each stage.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module ckt_clock_timer
#(
    parameter int TICK_CYCLES = ckt_pkg::CKT_TICK_CYCLES
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ckt_pkg::CKT_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer outputs
    output logic irq,
    output logic wdt_clk_2hz,
    output logic lcd_static_select,
    output logic stopwatch_run_control,
    output logic port0_direction
);
    import ckt_pkg::*;

    // ========================================================
    // Bus decode
    // ========================================================
    logic acc;
    logic [11:0] idx;
    logic hit_stage;
    logic hit_mask;
    logic hit_cause;
    logic hit_ctrl;
    logic wr;
    logic rd;

    always_comb
    begin
        acc = psel & penable;
        idx = paddr[CKT_AW-1:2];
        hit_stage = idx == CKT_IDX_STAGE;
        hit_mask = idx == CKT_IDX_MASK;
        hit_cause = idx == CKT_IDX_CAUSE;
        hit_ctrl = idx == CKT_IDX_CTRL;
        wr = acc & pwrite;
        rd = acc & ~pwrite;
    end

    // ========================================================
    // Divider chain
    // ========================================================
    // Bit 0 of chain is 128 Hz; bit 2 is 32 Hz ... bit 6 is 2 Hz.
    logic [31:0] tick_reg;
    logic [31:0] tick_next;
    logic [CKT_CHAIN_W-1:0] chain_reg;
    logic [CKT_CHAIN_W-1:0] chain_next;
    logic strobe;

    always_comb
    begin
        strobe = wr & hit_ctrl & pwdata[CKT_BIT_STROBE];
        tick_next = tick_reg + 32'h0000_0001;
        chain_next = chain_reg;
        if (strobe)
        begin
            tick_next = 32'h0000_0000;
            chain_next = '0;
        end
        else if (tick_reg >= 32'(TICK_CYCLES - 1))
        begin
            tick_next = 32'h0000_0000;
            chain_next = chain_reg + 7'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_reg <= 32'h0000_0000;
            chain_reg <= '0;
        end
        else
        begin
            tick_reg <= tick_next;
            chain_reg <= chain_next;
        end
    end

    logic [3:0] stage;
    assign stage = chain_reg[6:3];

    // ========================================================
    // Cause flags
    // ========================================================
    // A restart drops high stages to zero, which looks like a falling edge;
    // software clears that by reading the flags.
    logic [2:0] cause;
    logic [2:0] src;
    logic clr_cause;
    logic [2:0] clr_bits;

    assign src = {chain_reg[6], chain_reg[4], chain_reg[2]};
    assign clr_cause = rd & hit_cause;

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : gen_flag
            ckt_edge_flag u_flag
            (
                .pclk(pclk),
                .presetn(presetn),
                .stage(src[g]),
                .clear(clr_bits[g]),
                .flag(cause[g])
            );
        end
    endgenerate

    // ========================================================
    // Control registers
    // ========================================================
    logic [2:0] mask_reg;
    logic [2:0] mask_next;
    logic lcd_reg;
    logic lcd_next;
    logic run_reg;
    logic run_next;
    logic dir_reg;
    logic dir_next;

    always_comb
    begin
        mask_next = mask_reg;
        lcd_next = lcd_reg;
        run_next = run_reg;
        dir_next = dir_reg;
        if (wr & hit_mask)
        begin
            mask_next = pwdata[2:0];
            lcd_next = pwdata[CKT_BIT_LCD];
        end
        if (wr & hit_ctrl)
        begin
            run_next = pwdata[CKT_BIT_STOPWATCH_RUN_CONTROL];
            dir_next = pwdata[CKT_BIT_PORT0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask_reg <= CKT_MASK_RST;
            lcd_reg <= 1'b0;
            run_reg <= 1'b0;
            dir_reg <= 1'b0;
        end
        else
        begin
            mask_reg <= mask_next;
            lcd_reg <= lcd_next;
            run_reg <= run_next;
            dir_reg <= dir_next;
        end
    end

    // ========================================================
    // Read data, interrupt and outputs
    // ========================================================
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic err_reg;
    logic err_next;
    logic irq_reg;
    logic irq_next;
    logic wdt_reg;
    logic wdt_next;
    logic rdy_reg;
    logic rdy_next;

    always_comb
    begin
        rdata_next = 32'h0000_0000;
        err_next = 1'b0;
        rdy_next = psel & ~penable;
        if (psel & ~penable)
        begin
            err_next = ~(hit_stage | hit_mask | hit_cause | hit_ctrl);
            if (hit_stage)
            begin
                rdata_next[3:0] = stage;
            end
            if (hit_mask)
            begin
                rdata_next[3:0] = {lcd_reg, mask_reg};
            end
            if (hit_cause)
            begin
                rdata_next[2:0] = cause;
            end
            if (hit_ctrl)
            begin
                // Strobe bit stays zero on read.
                rdata_next[3:0] = {1'b0, run_reg, 1'b0, dir_reg};
            end
        end
        irq_next = |(cause & mask_reg);
        wdt_next = stage[3];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdata_reg <= 32'h0000_0000;
            err_reg <= 1'b0;
            irq_reg <= 1'b0;
            wdt_reg <= 1'b0;
            rdy_reg <= 1'b0;
        end
        else
        begin
            rdata_reg <= rdata_next;
            err_reg <= err_next;
            irq_reg <= irq_next;
            wdt_reg <= wdt_next;
            rdy_reg <= rdy_next;
        end
    end

    assign prdata = rdata_reg;
    assign pslverr = err_reg;
    assign pready = rdy_reg;
    assign irq = irq_reg;
    assign wdt_clk_2hz = wdt_reg;
    assign lcd_static_select = lcd_reg;
    assign stopwatch_run_control = run_reg;
    assign port0_direction = dir_reg;
    // Only flags that the read returned are cleared, so a fall between
    // the setup and the access cycle is not lost.
    assign clr_bits = {3{clr_cause}} & rdata_reg[2:0];

    // ========================================================
    // Checks
    // ========================================================
    sequence s_strobe;
        strobe;
    endsequence

    a_strobe_restart: assert property (@(posedge pclk)
        disable iff (!presetn)
        s_strobe |=> (chain_reg == '0) && (tick_reg == 32'h0000_0000))
        else $error("chain did not restart on strobe");
    a_stage_reset: assert property (@(posedge pclk)
        $rose(presetn) |-> stage == CKT_STAGE_RST)
        else $error("stage bits not zero after reset");
    a_ctrl_read_zero: assert property (@(posedge pclk)
        disable iff (!presetn)
        (psel && !penable && hit_ctrl) |=> prdata[CKT_BIT_STROBE] == 1'b0)
        else $error("strobe bit read back as one");
    a_mask_write: assert property (@(posedge pclk)
        disable iff (!presetn)
        (wr && hit_mask) |=> mask_reg == $past(pwdata[2:0]))
        else $error("mask write not taken");
    a_mask_reset: assert property (@(posedge pclk)
        $rose(presetn) |-> mask_reg == CKT_MASK_RST)
        else $error("mask not cleared at reset");
    a_irq_level: assert property (@(posedge pclk)
        disable iff (!presetn)
        ##1 irq == |($past(cause) & $past(mask_reg)))
        else $error("interrupt level wrong");
    a_cause_clear: assert property (@(posedge pclk)
        disable iff (!presetn)
        (clr_cause && !$fell(src[0]) && !$fell(src[1]) && !$fell(src[2]))
        |=> cause == ($past(cause) & ~$past(rdata_reg[2:0])))
        else $error("cause flags not cleared by read");
    a_cause_reset: assert property (@(posedge pclk)
        $rose(presetn) |-> cause == CKT_CAUSE_RST)
        else $error("cause flags not cleared at reset");
    a_stage_read: assert property (@(posedge pclk)
        disable iff (!presetn)
        (psel && !penable && hit_stage) |=> prdata[3:0] == $past(stage))
        else $error("stage read data wrong");
    a_wdt_follow: assert property (@(posedge pclk)
        disable iff (!presetn)
        ##1 wdt_clk_2hz == $past(stage[3]))
        else $error("watchdog clock does not follow 2 Hz stage");
endmodule

// file: bench/ckt_cpu_model.sv
// Purpose: CPU core model that reaches the clock timer over APB.
// Assumes: The slave may add wait states; the model waits for pready.
// Notes: One idle edge precedes every setup cycle.
`timescale 1ns/1ps
module ckt_cpu_model
(
    // Clock
    input wire logic pclk,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [ckt_pkg::CKT_AW-1:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    import ckt_pkg::*;
    // ========
    // Bus cycle
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0000_0000;
    end
    // The core never enables interrupts, so cause reads and mask writes
    // cannot race an interrupt entry.
    task automatic xfer(input logic [11:0] idx, input logic wr,
        input logic [3:0] d, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {28'h000_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        // pready ends this wait; if it never comes, only the bench timeout does.
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// file: bench/clock_timer_with_interrupts_test.sv
// Purpose: Self-checking bench for the clock timer.
// Assumes: A short base tick keeps the 2 Hz stage reachable.
// Notes: Chain times are checked with margins for the tick phase.
`timescale 1ns/1ps
module clock_timer_with_interrupts_test;
    import ckt_pkg::*;
    typedef struct packed
    {
        logic [11:0] idx;
        logic wr;
        logic [3:0] d;
        logic [3:0] q;
        logic e;
    } ckt_row_s;
    // The short tick stands for a prescaler matched to the crystal.
    localparam int TICK = 4;
    localparam ckt_row_s ROWS [9] = '{
        '{CKT_IDX_MASK, 1'b1, 4'hf, 4'h0, 1'b0},
        '{CKT_IDX_MASK, 1'b0, 4'h0, 4'hf, 1'b0},
        '{CKT_IDX_CAUSE, 1'b1, 4'h7, 4'h0, 1'b0},
        '{CKT_IDX_STAGE, 1'b1, 4'hf, 4'h0, 1'b0},
        '{CKT_IDX_CTRL, 1'b1, 4'h5, 4'h0, 1'b0},
        '{CKT_IDX_CTRL, 1'b0, 4'h0, 4'h5, 1'b0},
        '{CKT_IDX_CTRL, 1'b1, 4'hd, 4'h0, 1'b0},
        '{CKT_IDX_CTRL, 1'b0, 4'h0, 4'h5, 1'b0},
        '{12'h0001, 1'b0, 4'h0, 4'h0, 1'b1}};
    localparam logic [11:0] RST [4] = '{CKT_IDX_STAGE, CKT_IDX_MASK,
        CKT_IDX_CAUSE, CKT_IDX_CTRL};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, e;
    logic [CKT_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic irq, wdt_clk_2hz, lcd_static_select;
    logic stopwatch_run_control, port0_direction;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;
    // ========
    // Clock, timeout and instances
    always #4 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            results();
        end
    end
    ckt_cpu_model cpu (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    ckt_clock_timer #(.TICK_CYCLES(TICK)) DUT (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq),
        .wdt_clk_2hz(wdt_clk_2hz), .lcd_static_select(lcd_static_select),
        .stopwatch_run_control(stopwatch_run_control),
        .port0_direction(port0_direction));
    // ========
    // Tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [11:0] idx, output logic [31:0] r);
        cpu.xfer(idx, 1'b0, 4'h0, r, e);
    endtask
    task automatic wr(input logic [11:0] idx, input logic [3:0] d);
        logic [31:0] r;
        cpu.xfer(idx, 1'b1, d, r, e);
    endtask
    task automatic results();
        $display("tests_run=%0d errors=%0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ========
    // Main sequence
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ROWS[i])
        begin
            cpu.xfer(ROWS[i].idx, ROWS[i].wr, ROWS[i].d, q, e);
            if (!ROWS[i].wr)
                check(q, {28'h000_0000, ROWS[i].q});
            check(32'(e), 32'(ROWS[i].e));
        end
        check(32'({lcd_static_select, stopwatch_run_control,
            port0_direction}), 32'h7);
        $display("table done");
        // Masked 32 Hz fall, then enabled.
        wr(CKT_IDX_MASK, 4'h0);
        wr(CKT_IDX_CTRL, 4'h8);
        rd(CKT_IDX_CAUSE, q);
        rd(CKT_IDX_STAGE, q);
        check(q, 32'h0);
        repeat (40) @(posedge pclk);
        check(32'(irq), 32'h0);
        rd(CKT_IDX_STAGE, q);
        check(q, 32'h1);
        rd(CKT_IDX_CAUSE, q);
        check(q, 32'h1);
        rd(CKT_IDX_CAUSE, q);
        check(q, 32'h0);
        wr(CKT_IDX_MASK, 4'h1);
        repeat (20) @(posedge pclk);
        check(32'(irq), 32'h1);
        rd(CKT_IDX_CAUSE, q);
        repeat (2) @(posedge pclk);
        check(32'(irq), 32'h0);
        $display("32 Hz interrupt done");
        // Only the 2 Hz fall may raise the line.
        wr(CKT_IDX_MASK, 4'h4);
        wr(CKT_IDX_CTRL, 4'h8);
        rd(CKT_IDX_CAUSE, q);
        n = 0;
        while (irq !== 1'b1 && n < 700)
        begin
            @(posedge pclk);
            n++;
            if (n == 300)
                check(32'(wdt_clk_2hz), 32'h1);
        end
        check(32'(n > 480 && n < 530), 32'h1);
        rd(CKT_IDX_CAUSE, q);
        check(q, 32'h7);
        repeat (300) @(posedge pclk);
        wr(CKT_IDX_CTRL, 4'h8);
        rd(CKT_IDX_CAUSE, q);
        check(q & 32'h4, 32'h4);
        check(32'(wdt_clk_2hz), 32'h0);
        $display("2 Hz and restart done");
        // Reset in mid-run.
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        check(32'(irq), 32'h0);
        presetn <= 1'b1;
        foreach (RST[i])
        begin
            rd(RST[i], q);
            check(q, 32'h0);
        end
        $display("reset done");
        results();
    end
endmodule
